// file: inc/supervision_timer_pkg.sv
`default_nettype none
package supervision_timer_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_ALERT_CTRL = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN_SET = 4'h5;
  localparam logic [3:0] ADDR_IRQ_FLAG = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_SERVICE = 4'h8;
  localparam logic [3:0] ADDR_GUARD = 4'h9;
  localparam logic [3:0] ADDR_W = 4'h4;
  // Register fields, service key and timing constants.
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_WINDOW_BIT = 2;
  localparam int CTRL_LOCK_BIT = 7;
  localparam int ALERT_BIT = 0;
  localparam int CFG_PER_LSB = 0;
  localparam int CFG_WIN_LSB = 4;
  localparam logic [7:0] SERVICE_KEY = 8'ha5;
  localparam logic [3:0] PER_MAX = 4'h9;
  localparam logic [3:0] WIN_MAX = 4'hb;
  localparam logic [3:0] BASE_SHIFT = 4'h3;
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;
  // Reset defaults, replaced by the user-row values on the first edge after reset.
  localparam logic [7:0] CONFIG_RESET = 8'hbb;
  localparam logic [3:0] ALERT_RESET = 4'hb;
  // Enable and disable take this many cycles to settle.
  localparam logic [1:0] SYNC_CYCLES = 2'h2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic from_debug;
  } bus_req_t;

  typedef struct packed {
    logic enable;
    logic window_en;
    logic lock;
    logic [7:0] config_val;
    logic [3:0] alert_offset;
  } user_row_t;
endpackage
`default_nettype wire

// file: logic/supervision_timer.sv
// The strobed register port was left to the implementer.
`default_nettype none
module supervision_timer (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire supervision_timer_pkg::bus_req_t i_bus,
  input wire supervision_timer_pkg::user_row_t i_user_row,
  input wire logic i_guard_lock,
  output logic [7:0] o_rdata,
  output logic o_early_alert_irq,
  output logic o_system_reset,
  output logic o_running
);
  typedef enum logic [1:0] {ST_IDLE, ST_ENABLING, ST_RUN, ST_DISABLING} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [1:0] sync_cnt;
    logic loaded;
    logic enable;
    logic window_en;
    logic lock;
    logic [7:0] config_val;
    logic [3:0] alert_offset;
    logic alert_en;
    logic alert_flag;
    logic in_open;
    logic [supervision_timer_pkg::CNT_W-1:0] count;
    logic pend_valid;
    logic [3:0] pend_addr;
    logic [7:0] pend_data;
    logic guard_meta;
    logic guard_sync;
    logic sys_reset;
    logic [7:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [supervision_timer_pkg::CNT_W-1:0] cycles(input logic [3:0] code);
    cycles = supervision_timer_pkg::CNT_ONE << (code + supervision_timer_pkg::BASE_SHIFT);
  endfunction

  logic [3:0] per_code;
  logic [3:0] win_code;
  logic [supervision_timer_pkg::CNT_W-1:0] period_len;
  logic [supervision_timer_pkg::CNT_W-1:0] closed_len;
  logic [supervision_timer_pkg::CNT_W-1:0] alert_at;
  logic [supervision_timer_pkg::CNT_W-1:0] limit;
  logic wr_ok;
  logic busy;
  logic timed_out;
  logic alert_set;

  always_comb
  begin
    per_code = s_q.config_val[supervision_timer_pkg::CFG_PER_LSB +: 4];
    win_code = s_q.config_val[supervision_timer_pkg::CFG_WIN_LSB +: 4];
    // Out-of-range codes saturate at the longest documented count.
    if (per_code > supervision_timer_pkg::PER_MAX)
    begin
      per_code = supervision_timer_pkg::PER_MAX;
    end
    if (win_code > supervision_timer_pkg::WIN_MAX)
    begin
      win_code = supervision_timer_pkg::WIN_MAX;
    end
    period_len = cycles(per_code);
    closed_len = cycles(win_code);
    alert_at = cycles(s_q.alert_offset > supervision_timer_pkg::WIN_MAX ?
                      supervision_timer_pkg::WIN_MAX : s_q.alert_offset);
    // In window mode the period field measures the open window only.
    limit = (s_q.window_en && !s_q.in_open) ? closed_len : period_len;
    // The debugger is never stopped by the write guard.
    wr_ok = i_bus.wr && (!s_q.guard_sync || i_bus.from_debug);
    busy = s_q.phase != ST_IDLE;
    timed_out = s_q.count >= limit - supervision_timer_pkg::CNT_ONE;
    alert_set = 1'b0;
    if (s_q.phase == ST_RUN && !s_q.window_en && alert_at < period_len
        && s_q.count == period_len - alert_at - supervision_timer_pkg::CNT_ONE)
    begin
      alert_set = 1'b1;
    end
    // In window mode the warning falls halfway through the open window.
    if (s_q.phase == ST_RUN && s_q.window_en && s_q.in_open && s_q.count == (period_len >> 1))
    begin
      alert_set = 1'b1;
    end
  end

  always_comb
  begin
    s_d = s_q;
    // The guard pin is asynchronous to this clock.
    // Only the second stage feeds the write gate, so a metastable first stage never reaches it.
    s_d.guard_meta = i_guard_lock;
    s_d.guard_sync = s_q.guard_meta;
    s_d.sys_reset = 1'b0;
    // Read data stands for one cycle only and falls back to zero after it.
    s_d.rdata = 8'h00;
    if (!s_q.loaded)
    begin
      // Settings are taken from the user row on the first edge after power-on.
      s_d.loaded = 1'b1;
      s_d.enable = i_user_row.enable;
      s_d.window_en = i_user_row.window_en;
      s_d.lock = i_user_row.lock;
      s_d.config_val = i_user_row.config_val;
      s_d.alert_offset = i_user_row.alert_offset;
      s_d.phase = i_user_row.enable ? ST_ENABLING : ST_IDLE;
      s_d.sync_cnt = supervision_timer_pkg::SYNC_CYCLES;
    end
    else
    begin
      unique case (s_q.phase)
        ST_IDLE:
        begin
          s_d.count = '0;
          s_d.in_open = 1'b0;
          // There is one held write slot, so a later write during disabling replaces an earlier one.
          // Software that needs both must wait until the timer reads as stopped.
          if (s_q.pend_valid)
          begin
            s_d.pend_valid = 1'b0;
            if (s_q.pend_addr == supervision_timer_pkg::ADDR_CONFIG)
            begin
              s_d.config_val = s_q.pend_data;
            end
            else if (s_q.pend_addr == supervision_timer_pkg::ADDR_ALERT_CTRL)
            begin
              s_d.alert_offset = s_q.pend_data[3:0];
            end
            else
            begin
              s_d.window_en = s_q.pend_data[supervision_timer_pkg::CTRL_WINDOW_BIT];
              s_d.lock = s_q.pend_data[supervision_timer_pkg::CTRL_LOCK_BIT];
            end
          end
        end
        ST_ENABLING, ST_DISABLING:
        begin
          // Enabling and disabling both settle for a fixed count before the phase changes.
          // Protected registers stay closed throughout, so a half-applied setting is never seen.
          s_d.sync_cnt = s_q.sync_cnt - 2'h1;
          if (s_q.sync_cnt == 2'h1)
          begin
            s_d.phase = (s_q.phase == ST_ENABLING) ? ST_RUN : ST_IDLE;
          end
        end
        ST_RUN:
        begin
          s_d.count = s_q.count + supervision_timer_pkg::CNT_ONE;
          if (alert_set)
          begin
            s_d.alert_flag = 1'b1;
          end
          if (timed_out)
          begin
            s_d.count = '0;
            if (s_q.window_en && !s_q.in_open)
            begin
              s_d.in_open = 1'b1;
            end
            else
            begin
              s_d.sys_reset = 1'b1;
              s_d.in_open = 1'b0;
            end
          end
        end
        default:
        begin
          s_d.phase = ST_IDLE;
        end
      endcase

      if (wr_ok)
      begin
        unique case (i_bus.addr)
          supervision_timer_pkg::ADDR_CONTROL:
          begin
            if (i_bus.wdata[supervision_timer_pkg::CTRL_ENABLE_BIT] && s_q.phase == ST_IDLE)
            begin
              s_d.enable = 1'b1;
              s_d.phase = ST_ENABLING;
              s_d.sync_cnt = supervision_timer_pkg::SYNC_CYCLES;
            end
            else if (!i_bus.wdata[supervision_timer_pkg::CTRL_ENABLE_BIT] && s_q.phase == ST_RUN
                     && !s_q.lock)
            begin
              s_d.enable = 1'b0;
              s_d.phase = ST_DISABLING;
              s_d.sync_cnt = supervision_timer_pkg::SYNC_CYCLES;
            end
            if (s_q.phase == ST_DISABLING)
            begin
              s_d.pend_valid = 1'b1;
              s_d.pend_addr = i_bus.addr;
              s_d.pend_data = i_bus.wdata;
            end
            else if (!busy && !i_bus.wdata[supervision_timer_pkg::CTRL_ENABLE_BIT])
            begin
              s_d.window_en = i_bus.wdata[supervision_timer_pkg::CTRL_WINDOW_BIT];
              s_d.lock = i_bus.wdata[supervision_timer_pkg::CTRL_LOCK_BIT];
            end
          end
          supervision_timer_pkg::ADDR_CONFIG, supervision_timer_pkg::ADDR_ALERT_CTRL:
          begin
            if (s_q.phase == ST_DISABLING)
            begin
              s_d.pend_valid = 1'b1;
              s_d.pend_addr = i_bus.addr;
              s_d.pend_data = i_bus.wdata;
            end
            else if (!busy)
            begin
              if (i_bus.addr == supervision_timer_pkg::ADDR_CONFIG)
              begin
                s_d.config_val = i_bus.wdata;
              end
              else
              begin
                s_d.alert_offset = i_bus.wdata[3:0];
              end
            end
          end
          supervision_timer_pkg::ADDR_IRQ_EN_CLEAR:
          begin
            if (i_bus.wdata[supervision_timer_pkg::ALERT_BIT])
            begin
              s_d.alert_en = 1'b0;
            end
          end
          supervision_timer_pkg::ADDR_IRQ_EN_SET:
          begin
            if (i_bus.wdata[supervision_timer_pkg::ALERT_BIT])
            begin
              s_d.alert_en = 1'b1;
            end
          end
          supervision_timer_pkg::ADDR_IRQ_FLAG:
          begin
            // A new alert raised in this same cycle keeps the flag set.
            if (i_bus.wdata[supervision_timer_pkg::ALERT_BIT] && !alert_set)
            begin
              s_d.alert_flag = 1'b0;
            end
          end
          supervision_timer_pkg::ADDR_SERVICE:
          begin
            // A wrong key resets even while stopped.
            // A runaway write into this register is therefore harmless only when the write guard refuses it.
            if (i_bus.wdata != supervision_timer_pkg::SERVICE_KEY)
            begin
              s_d.sys_reset = 1'b1;
            end
            // A correct key in the closed window is still too early and counts as a fault.
            else if (s_q.phase == ST_RUN && s_q.window_en && !s_q.in_open)
            begin
              s_d.sys_reset = 1'b1;
              s_d.count = '0;
            end
            else if (s_q.phase == ST_RUN)
            begin
              s_d.count = '0;
              s_d.in_open = 1'b0;
            end
          end
          default:
          begin
          end
        endcase
      end

      if (i_bus.rd)
      begin
        unique case (i_bus.addr)
          supervision_timer_pkg::ADDR_CONTROL:
            s_d.rdata = {s_q.lock, 4'h0, s_q.window_en, s_q.enable, 1'b0};
          supervision_timer_pkg::ADDR_CONFIG:
            s_d.rdata = s_q.config_val;
          supervision_timer_pkg::ADDR_ALERT_CTRL:
            s_d.rdata = {4'h0, s_q.alert_offset};
          supervision_timer_pkg::ADDR_IRQ_EN_CLEAR, supervision_timer_pkg::ADDR_IRQ_EN_SET:
            s_d.rdata = {7'h00, s_q.alert_en};
          supervision_timer_pkg::ADDR_IRQ_FLAG:
            s_d.rdata = {7'h00, s_q.alert_flag};
          supervision_timer_pkg::ADDR_STATUS:
            s_d.rdata = {5'h00, s_q.in_open, busy && s_q.phase != ST_RUN, s_q.phase == ST_RUN};
          supervision_timer_pkg::ADDR_GUARD:
            s_d.rdata = {7'h00, s_q.guard_sync};
          default:
            s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_q <= '{phase: ST_IDLE, sync_cnt: 2'h0, loaded: 1'b0, enable: 1'b0, window_en: 1'b0, lock: 1'b0,
               config_val: supervision_timer_pkg::CONFIG_RESET, alert_offset: supervision_timer_pkg::ALERT_RESET,
               alert_en: 1'b0, alert_flag: 1'b0, in_open: 1'b0, count: '0, pend_valid: 1'b0,
               pend_addr: 4'h0, pend_data: 8'h00, guard_meta: 1'b0, guard_sync: 1'b0,
               sys_reset: 1'b0, rdata: 8'h00};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_early_alert_irq = s_q.alert_flag && s_q.alert_en;
  assign o_system_reset = s_q.sys_reset;
  assign o_running = s_q.phase == ST_RUN;
endmodule
`default_nettype wire

// file: tb/supervision_timer_asserts.sv
`default_nettype none
module supervision_timer_asserts (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire supervision_timer_pkg::bus_req_t i_bus,
  input wire supervision_timer_pkg::user_row_t i_user_row,
  input wire logic i_guard_lock,
  input wire logic [7:0] o_rdata,
  input wire logic o_early_alert_irq,
  input wire logic o_system_reset,
  input wire logic o_running
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] run_cnt_q;
  logic [1:0] guard_hist_q;
  logic svc_wr;
  logic ctl_wr;
  logic en_wr;
  assign svc_wr = i_bus.wr && i_bus.addr == supervision_timer_pkg::ADDR_SERVICE;
  // The guard reaches the write gate two edges late, so look at its value from then.
  assign ctl_wr = i_bus.wr && (i_bus.from_debug || !guard_hist_q[1])
    && i_bus.addr == supervision_timer_pkg::ADDR_CONTROL;
  assign en_wr = ctl_wr && i_bus.wdata[1];
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
    if (!i_arst_n)
      guard_hist_q <= 2'h0;
    else
      guard_hist_q <= {guard_hist_q[0], i_guard_lock};
  // A guarded service write may be refused, so every service write restarts this loose bound.
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
    if (!i_arst_n)
      run_cnt_q <= 16'h0000;
    else if (!o_running || o_system_reset || svc_wr)
      run_cnt_q <= 16'h0000;
    else
      run_cnt_q <= run_cnt_q + 16'h0001;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  reset_pulse_a:
    assert property (o_system_reset && !svc_wr |=> !o_system_reset) else $error("system reset wider than one cycle");
  bad_key_a:
    assert property (svc_wr && i_bus.from_debug && i_bus.wdata != supervision_timer_pkg::SERVICE_KEY
      |=> o_system_reset) else $error("wrong key gave no reset");
  irq_clear_a:
    assert property (i_bus.wr && i_bus.from_debug && i_bus.wdata[0]
      && i_bus.addr == supervision_timer_pkg::ADDR_IRQ_EN_CLEAR |=> !o_early_alert_irq)
    else $error("alert stays after enable clear");
  run_start_a:
    assert property (en_wr && !o_running && !$past(o_running) && !$past(o_running, 2) && !$past(en_wr)
      && !$past(en_wr, 2) |-> ##3 o_running) else $error("enable did not start");
  timeout_bound_a:
    assert property (run_cnt_q < 16'h5010) else $error("no timeout reset");
  status_read_a:
    assert property (i_bus.rd && i_bus.addr == supervision_timer_pkg::ADDR_STATUS
      |=> o_rdata[0] == $past(o_running)) else $error("status running bit wrong");
  control_read_a:
    assert property (i_bus.rd && i_bus.addr == supervision_timer_pkg::ADDR_CONTROL && o_running
      |=> o_rdata[1]) else $error("enable bit low while running");
  row_start_a:
    assert property ($rose(i_arst_n) && i_user_row.enable |-> ##[1:4] o_running) else $error("row enable ignored");
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_guard_lock = 1'b0;
  supervision_timer_pkg::bus_req_t i_bus = '0;
  supervision_timer_pkg::user_row_t i_user_row = '0;
  logic [7:0] o_rdata;
  logic o_early_alert_irq;
  logic o_system_reset;
  logic o_running;
  int n_fail = 0;
  int tests_run = 0;
  int n;
  logic [7:0] r;
  logic [7:0] q;

  supervision_timer u_supervision_timer (.i_ref_clk, .i_arst_n, .i_bus, .i_user_row, .i_guard_lock,
    .o_rdata, .o_early_alert_irq, .o_system_reset, .o_running);

  initial
    forever #12.5 i_ref_clk = ~i_ref_clk;

  function automatic int per_len(input logic [3:0] code);
    return 8 << code;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
    @(posedge i_ref_clk);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, from_debug: dbg};
    @(posedge i_ref_clk);
    i_bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, from_debug: 1'b0};
    @(posedge i_ref_clk);
    i_bus.rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // Edges until the chosen output is high: 0 system reset, 1 alert, 2 running.
  task automatic wait_for(input int sel, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge i_ref_clk);
      #1;
      cnt++;
    end
    while ((sel == 0 ? o_system_reset : sel == 1 ? o_early_alert_irq : o_running) !== 1'b1 && cnt < lim);
  endtask

  task automatic do_reset(input supervision_timer_pkg::user_row_t row);
    i_arst_n <= 1'b0;
    i_user_row <= row;
    repeat (16) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #500000;
    n_fail++;
    results();
  end

  initial
  begin
    r = $urandom(32'ha924);
    do_reset('{enable: 1'b0, window_en: 1'b0, lock: 1'b0, config_val: 8'h31, alert_offset: 4'h2});
    rd(supervision_timer_pkg::ADDR_CONFIG, r);
    chk("config load", 8'h31, r);
    rd(supervision_timer_pkg::ADDR_ALERT_CTRL, r);
    chk("offset load", 8'h02, r);
    rd(4'h3, r);
    chk("unmapped", 8'h00, r);
    // The guard input passes two flops, so give it three edges.
    i_guard_lock <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    wr(supervision_timer_pkg::ADDR_CONFIG, 8'h22, 1'b0);
    rd(supervision_timer_pkg::ADDR_CONFIG, r);
    chk("guarded write", 8'h31, r);
    wr(supervision_timer_pkg::ADDR_CONFIG, 8'h22, 1'b1);
    rd(supervision_timer_pkg::ADDR_CONFIG, r);
    chk("debug write", 8'h22, r);
    i_guard_lock <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    repeat (6)
    begin
      r = $urandom;
      r = {r[7:4] % 4'hc, r[3:0] % 4'ha};
      wr(supervision_timer_pkg::ADDR_CONFIG, r, 1'b0);
      rd(supervision_timer_pkg::ADDR_CONFIG, q);
      chk("config rw", r, q);
    end
    $display("test registers done");
    wr(supervision_timer_pkg::ADDR_CONFIG, 8'h01, 1'b0);
    wr(supervision_timer_pkg::ADDR_CONTROL, 8'h02, 1'b0);
    wait_for(2, 6, n);
    chk("enable delay", 1, n <= 4);
    wait_for(0, 40, n);
    chk("timeout", 1, n inside {[per_len(1) - 1 : per_len(1) + 2]});
    wr(supervision_timer_pkg::ADDR_CONFIG, 8'h77, 1'b0);
    repeat (4) @(posedge i_ref_clk);
    wr(supervision_timer_pkg::ADDR_SERVICE, supervision_timer_pkg::SERVICE_KEY, 1'b0);
    wait_for(0, 40, n);
    chk("service", 1, n inside {[per_len(1) - 2 : per_len(1) + 1]});
    rd(supervision_timer_pkg::ADDR_CONFIG, r);
    chk("config locked", 8'h01, r);
    r = $urandom;
    if (r == supervision_timer_pkg::SERVICE_KEY)
      r = 8'h00;
    wr(supervision_timer_pkg::ADDR_SERVICE, r, 1'b1);
    #1;
    chk("bad key", 1, o_system_reset);
    wr(supervision_timer_pkg::ADDR_CONTROL, 8'h00, 1'b0);
    wr(supervision_timer_pkg::ADDR_CONFIG, 8'h45, 1'b1);
    repeat (4) @(posedge i_ref_clk);
    chk("stopped", 0, o_running);
    rd(supervision_timer_pkg::ADDR_CONFIG, r);
    chk("held write", 8'h45, r);
    $display("test timeout done");
    wr(supervision_timer_pkg::ADDR_CONFIG, 8'h01, 1'b0);
    wr(supervision_timer_pkg::ADDR_ALERT_CTRL, 8'h00, 1'b0);
    wr(supervision_timer_pkg::ADDR_IRQ_EN_SET, 8'h01, 1'b0);
    wr(supervision_timer_pkg::ADDR_CONTROL, 8'h02, 1'b0);
    wait_for(2, 6, n);
    wait_for(1, 40, n);
    chk("alert time", 1, n inside {[per_len(1) - per_len(0) - 1 : per_len(1) - per_len(0) + 2]});
    wr(supervision_timer_pkg::ADDR_IRQ_EN_CLEAR, 8'h01, 1'b1);
    #1;
    chk("alert off", 0, o_early_alert_irq);
    rd(supervision_timer_pkg::ADDR_IRQ_FLAG, r);
    chk("flag sticky", 8'h01, r);
    wr(supervision_timer_pkg::ADDR_CONTROL, 8'h00, 1'b0);
    repeat (4) @(posedge i_ref_clk);
    wr(supervision_timer_pkg::ADDR_IRQ_FLAG, 8'h01, 1'b0);
    rd(supervision_timer_pkg::ADDR_IRQ_FLAG, r);
    chk("flag clear", 8'h00, r);
    $display("test alert done");
    wr(supervision_timer_pkg::ADDR_CONTROL, 8'h80, 1'b0);
    wr(supervision_timer_pkg::ADDR_CONTROL, 8'h82, 1'b0);
    wait_for(2, 6, n);
    wr(supervision_timer_pkg::ADDR_CONTROL, 8'h80, 1'b0);
    repeat (6) @(posedge i_ref_clk);
    chk("lock", 1, o_running);
    $display("test lock done");
    do_reset('{enable: 1'b1, window_en: 1'b1, lock: 1'b0, config_val: 8'h00, alert_offset: 4'h0});
    wait_for(2, 8, n);
    chk("row enable", 1, o_running);
    wr(supervision_timer_pkg::ADDR_SERVICE, supervision_timer_pkg::SERVICE_KEY, 1'b0);
    #1;
    chk("closed service", 1, o_system_reset);
    rd(supervision_timer_pkg::ADDR_CONTROL, r);
    chk("row window", 8'h06, r & 8'h86);
    $display("test window done");
    results();
  end
endmodule

bind supervision_timer supervision_timer_asserts u_supervision_timer_asserts (.i_ref_clk, .i_arst_n, .i_bus,
  .i_user_row, .i_guard_lock, .o_rdata, .o_early_alert_irq, .o_system_reset, .o_running);
`default_nettype wire
